/* File: hw/motion_pkg.sv */
// shared constants and types for the motion command link
package motion_pkg;
   // device clock and timing
   localparam int unsigned CLK_HZ = 200_000_000;
   localparam int unsigned SEC_MS = 1000;
   localparam int unsigned TIMEOUT_MS = 2500;
   localparam int unsigned SEC_CYCLES_DEF = CLK_HZ / 1000 * SEC_MS;
   localparam int unsigned TIMEOUT_CYCLES_DEF = CLK_HZ / 1000 * TIMEOUT_MS;
   // command bytes
   localparam logic [7:0] CMD_RD_DUAL = 8'h75;
   localparam logic [7:0] CMD_WR_DUAL = 8'h55;
   localparam logic [7:0] CMD_RD_SINGLE = 8'h76;
   localparam logic [7:0] CMD_WR_SINGLE = 8'h56;
   localparam logic [7:0] CMD_RESET = 8'h58;
   localparam logic [7:0] CMD_RD_SLEEP = 8'h79;
   localparam logic [7:0] CMD_WR_SLEEP = 8'h59;
   localparam logic [7:0] CMD_SLEEP = 8'h5a;
   localparam logic [7:0] CMD_RD_MOTION = 8'h61;
   // reply and argument characters
   localparam logic [7:0] CH_Y = 8'h59;
   localparam logic [7:0] CH_N = 8'h4e;
   localparam logic [7:0] CH_A = 8'h41;
   localparam logic [7:0] CH_M = 8'h4d;
   localparam logic [7:0] CH_PLUS = 8'h2b;
   localparam logic [7:0] CH_MINUS = 8'h2d;
   localparam logic [7:0] CH_0 = 8'h30;
   localparam logic [7:0] CH_1 = 8'h31;
   localparam logic [7:0] CH_ACK = 8'h06;
   localparam logic [7:0] CH_NACK = 8'h15;
   localparam logic [1:0] CONFIRM_LAST = 2'h3;
   localparam logic [1:0] ASCII_LAST = 2'h2;
   localparam logic [7:0] SLEEP_TIME_RST = 8'h00;
   // host register map, byte addresses
   localparam logic [3:0] REG_TX = 4'h0;
   localparam logic [3:0] REG_RX = 4'h4;
   localparam logic [3:0] REG_STAT = 4'h8;
   localparam int RX_VALID_BIT = 8;
   localparam int STAT_VALID_BIT = 0;
   localparam int STAT_OVR_BIT = 1;
   // device command state, gray along idle-arg-confirm-sleep
   typedef enum logic [1:0] {
      st_idle = 2'b00,
      st_arg = 2'b01,
      st_confirm = 2'b11,
      st_sleep = 2'b10
   } cmd_state_e;
   typedef enum logic [1:0] {
      dir_off = 2'b00,
      dir_plus = 2'b01,
      dir_minus = 2'b10
   } dir_sel_e;
endpackage

/* File: hw/motion_link.sv */
// byte link between host controller and motion device
`timescale 1ns/1ps
interface motion_link;
   logic h2d_valid;
   logic [7:0] h2d_data;
   logic d2h_valid;
   logic [7:0] d2h_data;
   modport dev (input h2d_valid, input h2d_data, output d2h_valid, output d2h_data);
   modport host (output h2d_valid, output h2d_data, input d2h_valid, input d2h_data);
endinterface

/* File: hw/motion_dev.sv */
// device end: command interpreter for direction, reset and sleep commands
//
// The address map and the Avalon-MM interface to the registers were left to the implementer.
`timescale 1ns/1ps
// Notes on behaviour
// - 0x75 returns dual setting, N or Y
// - 0x55 plus Y/N sets dual mode
// - dual mode replies carry plus or minus
// - 0x76 returns single setting A, plus, minus
// - 0x56 plus character sets single direction
// - single mode reports only chosen direction
// - single mode keeps plain reply format
// - 0x58 acks, then expects digits 1234
// - good reset confirm acks, restores defaults
// - bad digit or timeout nacks, keeps state
// - lower y returns sleep seconds
// - upper Y plus value stores sleep seconds
// - zero sleep time disables sleep timer
// - 0x5a acks, confirm 1234, ack, sleep
// - bad sleep confirm nacks, stays awake
// - wake on timer, pin edge, character
// - unsolicited mode reports awake motion events, merging those seen while a report is pending
// - ascii mode numbers are three digits
module motion_dev
   import motion_pkg::*;
#(
   parameter int unsigned SEC_CYCLES = SEC_CYCLES_DEF,
   parameter int unsigned TIMEOUT_CYCLES = TIMEOUT_CYCLES_DEF
) (
   input wire logic ref_clk,
   input wire logic rst,
   motion_link.dev link,
   input wire logic motion_evt,
   input wire logic motion_dir_plus,
   input wire logic unsol_en,
   input wire logic ascii_mode,
   input wire logic sleep_wake_pin,
   output logic sleeping,
   output logic motion_flag
);
   cmd_state_e st_r, st_nxt;
   dir_sel_e single_r, single_nxt;
   logic [7:0] cmd_r, cmd_nxt, acc_r, acc_nxt, stime_r, stime_nxt, left_r, left_nxt;
   logic [1:0] idx_r, idx_nxt, tx_len_r;
   logic dual_r, dual_nxt, seen_r, seen_nxt, plus_r, plus_nxt, pend_r, pend_nxt;
   logic [31:0] to_r, to_nxt, sec_r;
   logic [23:0] tx_buf_r, ld_buf;
   logic [1:0] ld_len;
   logic ld, pin_q_r, out_valid_r, sleeping_r;
   logic [7:0] out_data_r;

   // three decimal characters of a byte, most significant first
   function automatic logic [23:0] dec3(input logic [7:0] v);
      logic [7:0] h, t, u;
      h = v / 8'd100;
      t = (v / 8'd10) % 8'd10;
      u = v % 8'd10;
      return {CH_0 + h, CH_0 + t, CH_0 + u};
   endfunction

   // received byte decode
   wire rx = link.h2d_valid;
   wire [7:0] rxd = link.h2d_data;
   wire [7:0] digit = rxd - CH_0;
   wire sec_tick = (sec_r == SEC_CYCLES - 1);
   wire timeout = (to_r == TIMEOUT_CYCLES - 1);
   wire pin_edge = (sleep_wake_pin != pin_q_r);
   wire idle_tx = (tx_len_r == 2'd0);
   // number reply, one byte or three characters
   wire [23:0] num_buf = ascii_mode ? dec3(stime_r) : {stime_r, 16'h0};
   wire [1:0] num_len = ascii_mode ? 2'd3 : 2'd1;
   // in single mode a motion event counts only in the chosen direction
   wire dir_ok = dual_r || single_r == dir_off || (single_r == dir_plus && motion_dir_plus)
      || (single_r == dir_minus && !motion_dir_plus);
   wire qual = motion_evt && dir_ok && st_r != st_sleep;
   // status reply and unsolicited report characters
   wire [7:0] dir_ch = plus_r ? CH_PLUS : CH_MINUS;
   wire [7:0] stat_ch = !seen_r ? CH_N : (dual_r ? dir_ch : CH_Y);
   wire [7:0] unsol_ch = dual_r ? dir_ch : CH_M;
   wire [7:0] single_ch = single_r == dir_plus ? CH_PLUS : (single_r == dir_minus ? CH_MINUS : CH_A);
   wire timer_done = stime_r != 8'h00 && sec_tick && left_r == 8'h01;

   // command sequencing, settings and reply loading
   always_comb begin
      st_nxt = st_r;
      cmd_nxt = cmd_r;
      idx_nxt = idx_r;
      acc_nxt = acc_r;
      dual_nxt = dual_r;
      single_nxt = single_r;
      stime_nxt = stime_r;
      left_nxt = left_r;
      seen_nxt = seen_r;
      plus_nxt = plus_r;
      pend_nxt = pend_r;
      ld = 1'b0;
      ld_len = 2'd1; // every reply but a number is one byte
      ld_buf = 24'h0;
      // waiting states time out unless bytes keep coming
      to_nxt = (rx || !(st_r == st_arg || st_r == st_confirm)) ? 32'h0 : to_r + 32'h1;
      unique case (st_r)
         st_idle: begin
            if (rx) begin
               case (rxd)
                  CMD_RD_DUAL: begin
                     ld = 1'b1;
                     ld_buf = {dual_r ? CH_Y : CH_N, 16'h0};
                  end
                  CMD_RD_SINGLE: begin
                     ld = 1'b1;
                     ld_buf = {single_ch, 16'h0};
                  end
                  CMD_RD_SLEEP: begin
                     ld = 1'b1;
                     ld_len = num_len;
                     ld_buf = num_buf;
                  end
                  CMD_RD_MOTION: begin
                     ld = 1'b1;
                     ld_buf = {stat_ch, 16'h0};
                     seen_nxt = 1'b0;
                  end
                  CMD_WR_DUAL, CMD_WR_SINGLE, CMD_WR_SLEEP: begin
                     st_nxt = st_arg;
                     cmd_nxt = rxd;
                     idx_nxt = 2'd0;
                     acc_nxt = 8'h00;
                  end
                  CMD_RESET, CMD_SLEEP: begin
                     ld = 1'b1;
                     ld_buf = {CH_ACK, 16'h0};
                     st_nxt = st_confirm;
                     cmd_nxt = rxd;
                     idx_nxt = 2'd0;
                  end
                  default: ;
               endcase
            end
         end
         st_arg: begin
            if (timeout || rx) st_nxt = st_idle;
            if (rx && !timeout) begin
               if (cmd_r == CMD_WR_DUAL) begin
                  if (rxd == CH_Y) dual_nxt = 1'b1;
                  else if (rxd == CH_N) dual_nxt = 1'b0;
               end else if (cmd_r == CMD_WR_SINGLE) begin
                  if (rxd == CH_A) single_nxt = dir_off;
                  else if (rxd == CH_PLUS) single_nxt = dir_plus;
                  else if (rxd == CH_MINUS) single_nxt = dir_minus;
               end else if (ascii_mode) begin
                  // wraps modulo 256 if the host sends more than 255
                  acc_nxt = 8'(acc_r * 8'd10 + digit);
                  idx_nxt = idx_r + 2'd1;
                  if (idx_r == ASCII_LAST) stime_nxt = acc_nxt;
                  else st_nxt = st_arg;
               end else begin
                  stime_nxt = rxd;
               end
            end
         end
         st_confirm: begin
            if (timeout || (rx && rxd != CH_1 + {6'h0, idx_r})) begin
               ld = 1'b1;
               ld_buf = {CH_NACK, 16'h0};
               st_nxt = st_idle;
            end else if (rx && idx_r != CONFIRM_LAST) begin
               idx_nxt = idx_r + 2'd1;
            end else if (rx) begin
               ld = 1'b1;
               ld_buf = {CH_ACK, 16'h0};
               if (cmd_r == CMD_RESET) begin
                  st_nxt = st_idle;
                  dual_nxt = 1'b0;
                  single_nxt = dir_off;
                  stime_nxt = SLEEP_TIME_RST;
                  seen_nxt = 1'b0;
                  plus_nxt = 1'b0;
                  pend_nxt = 1'b0;
               end else begin
                  st_nxt = st_sleep;
                  left_nxt = stime_r;
               end
            end
         end
         st_sleep: begin
            // the waking character is dropped, not decoded
            if (rx || pin_edge || timer_done) begin
               st_nxt = st_idle;
            end else if (sec_tick && left_r != 8'h00) begin
               left_nxt = left_r - 8'h01;
            end
         end
      endcase
      // unsolicited report waits for a quiet transmitter
      if (pend_r && !ld && idle_tx) begin
         ld = 1'b1;
         ld_buf = {unsol_ch, 16'h0};
         pend_nxt = 1'b0;
      end
      // a new event beats a clear in the same cycle
      if (qual) begin
         seen_nxt = 1'b1;
         plus_nxt = motion_dir_plus;
         if (unsol_en) pend_nxt = 1'b1;
      end
   end

   // state registers
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         st_r <= st_idle;
         cmd_r <= 8'h00;
         idx_r <= 2'd0;
         acc_r <= 8'h00;
         dual_r <= 1'b0;
         single_r <= dir_off;
         stime_r <= SLEEP_TIME_RST;
         left_r <= 8'h00;
         to_r <= 32'h0;
         seen_r <= 1'b0;
         plus_r <= 1'b0;
         pend_r <= 1'b0;
         sleeping_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         cmd_r <= cmd_nxt;
         idx_r <= idx_nxt;
         acc_r <= acc_nxt;
         dual_r <= dual_nxt;
         single_r <= single_nxt;
         stime_r <= stime_nxt;
         left_r <= left_nxt;
         to_r <= to_nxt;
         seen_r <= seen_nxt;
         plus_r <= plus_nxt;
         pend_r <= pend_nxt;
         sleeping_r <= (st_nxt == st_sleep);
      end
   end

   // seconds divider, free running so the first second may be short
   always_ff @(posedge ref_clk) begin
      if (rst || sec_tick) sec_r <= 32'h0;
      else sec_r <= sec_r + 32'h1;
   end

   // reply shifter, one byte per cycle, newest load wins
   always_ff @(posedge ref_clk) begin
      // no reset, so the pin level after reset never reads as an edge
      pin_q_r <= sleep_wake_pin;
      if (rst) begin
         tx_len_r <= 2'd0;
         tx_buf_r <= 24'h0;
         out_valid_r <= 1'b0;
         out_data_r <= 8'h00;
      end else begin
         out_valid_r <= !idle_tx;
         out_data_r <= idle_tx ? 8'h00 : tx_buf_r[23:16];
         if (ld) begin
            tx_len_r <= ld_len;
            tx_buf_r <= ld_buf;
         end else if (!idle_tx) begin
            tx_len_r <= tx_len_r - 2'd1;
            tx_buf_r <= {tx_buf_r[15:0], 8'h00};
         end
      end
   end

   assign link.d2h_valid = out_valid_r;
   assign link.d2h_data = out_data_r;
   assign sleeping = sleeping_r;
   assign motion_flag = seen_r;
endmodule

/* File: hw/motion_host.sv */
// host end: avalon slave that sends and collects link bytes
`timescale 1ns/1ps
module motion_host
   import motion_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst,
   motion_link.host link,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest
);
   logic ack_r, rx_valid_r, ovr_r, tx_valid_r, waitreq_r;
   logic [7:0] rx_data_r, tx_data_r;
   logic [31:0] rdata_r;

   // a request completes one cycle after it is first seen
   wire req = avs_read || avs_write;
   wire done = req && ack_r;
   wire wr_tx = done && avs_write && avs_address == REG_TX;
   wire rd_rx = done && avs_read && avs_address == REG_RX;
   wire rd_stat = done && avs_read && avs_address == REG_STAT;
   // read mux, unmapped addresses read zero
   wire [31:0] rx_word = {23'h0, rx_valid_r, rx_data_r};
   wire [31:0] stat_word = {30'h0, ovr_r, rx_valid_r};
   wire [31:0] rmux = avs_address == REG_RX ? rx_word : (avs_address == REG_STAT ? stat_word : 32'h0);

   // bus handshake and read data
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         ack_r <= 1'b0;
         waitreq_r <= 1'b1;
         rdata_r <= 32'h0;
      end else begin
         ack_r <= req && !ack_r;
         waitreq_r <= !(req && !ack_r);
         rdata_r <= (req && !ack_r && avs_read) ? rmux : rdata_r;
      end
   end

   // outgoing byte strobe
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         tx_valid_r <= 1'b0;
         tx_data_r <= 8'h00;
      end else begin
         tx_valid_r <= wr_tx;
         tx_data_r <= wr_tx ? avs_writedata[7:0] : tx_data_r;
      end
   end

   // incoming byte holding, arrival wins over a read clear
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         rx_valid_r <= 1'b0;
         rx_data_r <= 8'h00;
         ovr_r <= 1'b0;
      end else begin
         rx_valid_r <= link.d2h_valid || (rx_valid_r && !rd_rx);
         rx_data_r <= link.d2h_valid ? link.d2h_data : rx_data_r;
         ovr_r <= (link.d2h_valid && rx_valid_r && !rd_rx) || (ovr_r && !rd_stat);
      end
   end

   assign link.h2d_valid = tx_valid_r;
   assign link.h2d_data = tx_data_r;
   assign avs_readdata = rdata_r;
   assign avs_waitrequest = waitreq_r;
endmodule

/* File: bench/motion_properties.sv */
// link checker: reply timing and contents at the device end
`timescale 1ns/1ps
module motion_properties
   import motion_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic h2d_valid,
   input wire logic [7:0] h2d_data,
   input wire logic d2h_valid,
   input wire logic [7:0] d2h_data,
   input wire logic sleeping
);
   logic arg_r;
   logic conf_r;
   logic zcmd_r;
   logic [1:0] dig_r;
   // decode of host bytes; argument and confirm bytes are not commands
   wire cmd_ok = h2d_valid && !arg_r && !conf_r && !sleeping;
   wire is_wr = h2d_data == CMD_WR_DUAL || h2d_data == CMD_WR_SINGLE || h2d_data == CMD_WR_SLEEP;
   wire is_conf = h2d_data == CMD_RESET || h2d_data == CMD_SLEEP;
   wire conf_in = h2d_valid && conf_r;
   wire dig_ok = h2d_data == CH_1 + {6'h00, dig_r};
   wire dig_last = conf_in && dig_ok && dig_r == CONFIRM_LAST;
   // tracks pending argument and confirm digits; binary number mode only
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         arg_r <= 1'b0;
         conf_r <= 1'b0;
         zcmd_r <= 1'b0;
         dig_r <= 2'h0;
      end else begin
         // held until the argument byte itself arrives
         if (cmd_ok && is_wr) arg_r <= 1'b1;
         else if (h2d_valid) arg_r <= 1'b0;
         if (cmd_ok && is_conf) begin
            conf_r <= 1'b1;
            zcmd_r <= h2d_data == CMD_SLEEP;
            dig_r <= 2'h0;
         end else if (conf_in) begin
            conf_r <= dig_ok && !dig_last;
            dig_r <= dig_r + 2'h1;
         end else if (d2h_valid && d2h_data == CH_NACK) begin
            conf_r <= 1'b0; // timeout abort
         end
      end
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   sequence reply_s(logic [7:0] c);
      d2h_valid && d2h_data == c;
   endsequence
   sequence quiet_s;
      !d2h_valid [*4];
   endsequence
   rd_dual_a: assert property (cmd_ok && h2d_data == CMD_RD_DUAL |-> ##2 (reply_s(CH_N) or reply_s(CH_Y)))
      else $error("dual read reply wrong");
   rd_single_a: assert property (cmd_ok && h2d_data == CMD_RD_SINGLE |->
      ##2 d2h_valid && (d2h_data == CH_A || d2h_data == CH_PLUS || d2h_data == CH_MINUS))
      else $error("single read reply wrong");
   rd_sleep_a: assert property (cmd_ok && h2d_data == CMD_RD_SLEEP |-> ##2 d2h_valid)
      else $error("sleep time read gave no reply");
   conf_ack_a: assert property (cmd_ok && is_conf |-> ##2 reply_s(CH_ACK))
      else $error("confirm command not acked");
   conf_done_a: assert property (dig_last |-> ##2 reply_s(CH_ACK))
      else $error("good confirm sequence not acked");
   conf_bad_a: assert property (conf_in && !dig_ok |-> ##2 reply_s(CH_NACK))
      else $error("wrong digit not nacked");
   bad_awake_a: assert property (conf_in && !dig_ok && zcmd_r |-> ##1 !sleeping [*4])
      else $error("slept after wrong digit");
   sleep_enter_a: assert property (dig_last && zcmd_r |=> sleeping)
      else $error("no sleep after good confirm");
   wake_char_a: assert property (sleeping && h2d_valid |-> ##[1:2] !sleeping)
      else $error("character did not wake");
   wake_quiet_a: assert property (sleeping && h2d_valid |-> ##1 quiet_s)
      else $error("waking character answered");
endmodule

/* File: bench/test_motion_direction_sleep_cmds.sv */
// bench: host and device ends joined over the byte link
`timescale 1ns/1ps
module test_motion_direction_sleep_cmds;
   import motion_pkg::*;
   localparam int unsigned SEC = 20;
   localparam int unsigned TO = 50;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic motion_evt = 1'b0;
   logic motion_dir_plus = 1'b0;
   logic unsol_en = 1'b0;
   logic ascii_mode = 1'b0;
   logic sleep_wake_pin = 1'b1;
   logic sleeping;
   logic motion_flag;
   logic [3:0] avs_address = 4'h0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   int mismatches = 0;
   int checks = 0;
   logic [7:0] rxq[$];
   logic [7:0] dual_tab[3] = '{CH_Y, CH_N, 8'h51};
   logic [7:0] single_tab[4] = '{CH_A, CH_PLUS, CH_MINUS, 8'h3f};
   logic [7:0] dual_x;
   logic [7:0] single_x;
   logic [7:0] c;
   logic [31:0] rd;
   int n;
   motion_link lk();
   motion_dev #(.SEC_CYCLES(SEC), .TIMEOUT_CYCLES(TO)) u_motion_dev (.ref_clk(ref_clk), .rst(rst), .link(lk),
      .motion_evt(motion_evt), .motion_dir_plus(motion_dir_plus), .unsol_en(unsol_en), .ascii_mode(ascii_mode),
      .sleep_wake_pin(sleep_wake_pin), .sleeping(sleeping), .motion_flag(motion_flag));
   motion_host u_motion_host (.ref_clk(ref_clk), .rst(rst), .link(lk), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest));
   motion_properties u_motion_properties (.ref_clk(ref_clk), .rst(rst), .h2d_valid(lk.h2d_valid),
      .h2d_data(lk.h2d_data), .d2h_valid(lk.d2h_valid), .d2h_data(lk.d2h_data), .sleeping(sleeping));
   initial forever #2.5 ref_clk = ~ref_clk;
   // every device byte is queued, so fast ascii triples are not lost
   always @(posedge ref_clk) if (lk.d2h_valid === 1'b1) rxq.push_back(lk.d2h_data);
   task end_sim;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   task hang(input string nm);
      mismatches++;
      $display("ERROR %s expected answer seen timeout", nm);
      end_sim();
   endtask
   // avalon transfer: request held until waitrequest is sampled low
   task av(input logic [3:0] a, input logic w, input logic [31:0] d);
      @(posedge ref_clk);
      avs_address <= a;
      avs_write <= w;
      avs_read <= !w;
      avs_writedata <= d;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (avs_waitrequest !== 1'b0) hang("waitrequest");
   endtask
   task send(input logic [7:0] b);
      av(REG_TX, 1'b1, {24'h0, b});
   endtask
   task get(input string nm, input logic [7:0] e);
      n = 0;
      while (rxq.size() == 0 && n < 400) begin
         @(posedge ref_clk);
         n++;
      end
      if (rxq.size() == 0) hang(nm);
      else chk(nm, {24'h0, e}, {24'h0, rxq.pop_front()});
   endtask
   task cmd(input logic [7:0] b, input logic [7:0] e, input string nm);
      send(b);
      get(nm, e);
   endtask
   task confirm;
      for (int d = 0; d < 3; d++) send(CH_1 + 8'(d));
      cmd(CH_1 + 8'h3, CH_ACK, "confirm done");
   endtask
   task motion(input logic p);
      @(posedge ref_clk);
      motion_evt <= 1'b1;
      motion_dir_plus <= p;
      @(posedge ref_clk);
      motion_evt <= 1'b0;
   endtask
   function automatic logic [7:0] upd(input logic [7:0] old, input logic [7:0] v, input logic ok);
      return ok ? v : old;
   endfunction
   initial begin
      void'($urandom(32'hd6834cab));
      repeat (3) @(posedge ref_clk);
      rst <= 1'b0;
      dual_x = CH_N;
      single_x = CH_A;
      cmd(CMD_RD_DUAL, CH_N, "dual default");
      cmd(CMD_RD_SINGLE, CH_A, "single default");
      cmd(CMD_RD_SLEEP, SLEEP_TIME_RST, "sleep default");
      av(REG_RX, 1'b0, 32'h0);
      chk("rx word", 32'h100, {23'h0, rd[8:0]});
      av(REG_STAT, 1'b0, 32'h0);
      chk("stat overrun", 32'h2, rd);
      av(REG_STAT, 1'b0, 32'h0);
      chk("stat cleared", 32'h0, rd);
      av(4'hc, 1'b0, 32'h0);
      chk("unmapped", 32'h0, rd);
      // every setting code first, then random ones with bad characters mixed in
      for (int i = 0; i < 10; i++) begin
         c = dual_tab[i < 3 ? i : $urandom_range(2)];
         send(CMD_WR_DUAL);
         send(c);
         dual_x = upd(dual_x, c, c == CH_Y || c == CH_N);
         cmd(CMD_RD_DUAL, dual_x, "dual");
         c = single_tab[i < 4 ? i : $urandom_range(3)];
         send(CMD_WR_SINGLE);
         send(c);
         single_x = upd(single_x, c, c == CH_A || c == CH_PLUS || c == CH_MINUS);
         cmd(CMD_RD_SINGLE, single_x, "single");
      end
      send(CMD_WR_DUAL);
      send(CH_Y);
      unsol_en <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         c = 8'($urandom_range(1));
         motion(c[0]);
         get("dual report", c[0] ? CH_PLUS : CH_MINUS);
      end
      unsol_en <= 1'b0;
      motion(1'b0);
      cmd(CMD_RD_MOTION, CH_MINUS, "dual status");
      chk("flag cleared", 32'h0, {31'h0, motion_flag});
      send(CMD_WR_DUAL);
      send(CH_N);
      send(CMD_WR_SINGLE);
      send(CH_PLUS);
      motion(1'b0);
      cmd(CMD_RD_MOTION, CH_N, "single other dir");
      motion(1'b1);
      cmd(CMD_RD_MOTION, CH_Y, "single chosen dir");
      unsol_en <= 1'b1;
      motion(1'b1);
      get("single report", CH_M);
      unsol_en <= 1'b0;
      c = 8'($urandom_range(255));
      send(CMD_WR_SLEEP);
      send(c);
      cmd(CMD_RD_SLEEP, c, "sleep time");
      ascii_mode <= 1'b1;
      c = 8'($urandom_range(255));
      send(CMD_WR_SLEEP);
      send(CH_0 + c / 100);
      send(CH_0 + c / 10 % 10);
      send(CH_0 + c % 10);
      send(CMD_RD_SLEEP);
      get("ascii hundreds", CH_0 + c / 100);
      get("ascii tens", CH_0 + c / 10 % 10);
      get("ascii units", CH_0 + c % 10);
      ascii_mode <= 1'b0;
      send(CMD_WR_DUAL);
      send(CH_Y);
      cmd(CMD_RESET, CH_ACK, "reset ack");
      send(CH_1);
      cmd(CH_1 + 8'h2, CH_NACK, "reset bad digit");
      cmd(CMD_RD_DUAL, CH_Y, "dual kept");
      cmd(CMD_RESET, CH_ACK, "reset ack");
      confirm();
      cmd(CMD_RD_DUAL, CH_N, "dual after reset");
      cmd(CMD_RD_SINGLE, CH_A, "single after reset");
      cmd(CMD_RD_SLEEP, SLEEP_TIME_RST, "sleep after reset");
      // each digit restarts the inactivity timer, silence then aborts
      cmd(CMD_SLEEP, CH_ACK, "sleep ack");
      send(CH_1);
      repeat (TO - 15) @(posedge ref_clk);
      send(CH_1 + 8'h1);
      repeat (TO - 15) @(posedge ref_clk);
      chk("no early nack", 32'h0, rxq.size());
      get("timeout nack", CH_NACK);
      cmd(CMD_SLEEP, CH_ACK, "sleep ack");
      cmd(CH_1 + 8'h1, CH_NACK, "sleep bad digit");
      chk("stays awake", 32'h0, {31'h0, sleeping});
      send(CMD_WR_SLEEP);
      send(8'h03);
      cmd(CMD_SLEEP, CH_ACK, "sleep ack");
      confirm();
      chk("asleep", 32'h1, {31'h0, sleeping});
      n = 0;
      while (sleeping === 1'b1 && n < 5 * SEC) begin
         @(posedge ref_clk);
         n++;
      end
      chk("timer wake", 32'h1, {31'h0, n >= 2 * SEC - 4 && n <= 3 * SEC + 4});
      send(CMD_WR_SLEEP);
      send(8'h00);
      cmd(CMD_SLEEP, CH_ACK, "sleep ack");
      confirm();
      repeat (5 * SEC) @(posedge ref_clk);
      chk("no timer wake", 32'h1, {31'h0, sleeping});
      sleep_wake_pin <= ~sleep_wake_pin;
      repeat (4) @(posedge ref_clk);
      chk("pin wake", 32'h0, {31'h0, sleeping});
      cmd(CMD_SLEEP, CH_ACK, "sleep ack");
      confirm();
      send(CMD_RD_DUAL);
      repeat (10) @(posedge ref_clk);
      chk("char wake", 32'h0, {31'h0, sleeping});
      chk("char dropped", 32'h0, rxq.size());
      end_sim();
   end
endmodule
